// [ebrw_pkg.sv]
// Package for the external bus ready wait-state controller
// Notes on behaviour
// - Ready input may stretch each bus cycle that has ready_en set
// - Ready active level is selectable
// - Synchronous mode samples ready without synchroniser
// - Asynchronous mode adds synchroniser, one wait minimum
// - First sample placed by programmed phase lengths
// - Inactive ready inserts one more wait state
// - Active ready ends the running cycle
// - Sampling point differs between sync and async
// - Access phase waits complete before ready evaluation
// - Read data captured on strobe-raising edge
`default_nettype none
package ebrw_pkg;
	localparam int          EBRW_PHASE_W    = 5;
	localparam int          EBRW_DATA_W     = 16;
	localparam logic [4:0]  EBRW_PHASE_ONE  = 5'h01;
	localparam logic [4:0]  EBRW_PHASE_ZERO = 5'h00;
	localparam logic [15:0] EBRW_DATA_RST   = 16'h0000;

	typedef enum logic [3:0] {
		EBRW_IDLE   = 4'h1,
		EBRW_ACCESS = 4'h2,
		EBRW_RDYW   = 4'h4,
		EBRW_DONE   = 4'h8
	} ebrw_state_t;

	// Cycle request as presented by the bus controller
	typedef struct packed {
		logic       start;
		logic       write;
		logic       ready_en;
		logic [4:0] access_phase_len;
	} ebrw_req_t;

	typedef struct packed {
		ebrw_state_t state;
		logic [4:0]  cnt;
		logic        write;
		logic        ready_en;
		logic        strobe_b;
		logic        busy;
		logic        done;
		logic        ready_wait_phase;
		logic        async_mode;
		logic [15:0] rdata;
	} ebrw_regs_t;
endpackage
`default_nettype wire

// [ebrw_sync.sv]
// Two-flop synchroniser for the ready input
`timescale 1ns/10ps
`default_nettype none
module ebrw_sync (
	input  wire logic ref_clk,
	input  wire logic rst_b,
	input  wire logic din,
	output logic      dout
);
	logic meta;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta <= 1'b0;
			dout <= 1'b0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule
`default_nettype wire

// [ebrw_ctrl.sv]
// Ready-controlled wait-state sequencer for external bus cycles
`timescale 1ns/10ps
`default_nettype none
module ebrw_ctrl #(
	parameter int DATA_W = ebrw_pkg::EBRW_DATA_W
) (
	input  wire logic              ref_clk,
	input  wire logic              rst_b,
	input  wire ebrw_pkg::ebrw_req_t req,
	input  wire logic              ready_pin,
	input  wire logic              ready_active_high,
	input  wire logic              ready_async,
	input  wire logic [DATA_W-1:0] data_in,
	output logic                   busy,
	output logic                   strobe_b,
	output logic                   cycle_done,
	output logic                   ready_wait_phase,
	output logic [DATA_W-1:0]      read_data
);
	ebrw_pkg::ebrw_regs_t r;
	ebrw_pkg::ebrw_regs_t next_r;
	logic ready_norm;
	logic ready_synced;
	logic ready_seen;

	// Polarity first so both paths see an active-true ready
	assign ready_norm = ready_pin ~^ ready_active_high;

	ebrw_sync u_sync (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.din     (ready_norm),
		.dout    (ready_synced)
	);

	// Async path sees ready two edges later, moving its sample point
	assign ready_seen = r.async_mode ? ready_synced : ready_norm;

	always_comb begin
		next_r      = r;
		next_r.done = 1'b0;
		unique case (r.state)
			ebrw_pkg::EBRW_IDLE: begin
				if (req.start) begin
					next_r.state            = ebrw_pkg::EBRW_ACCESS;
					next_r.cnt              = (req.access_phase_len == ebrw_pkg::EBRW_PHASE_ZERO)
						? ebrw_pkg::EBRW_PHASE_ONE : req.access_phase_len;
					next_r.write            = req.write;
					next_r.ready_en         = req.ready_en;
					next_r.async_mode       = ready_async;
					next_r.strobe_b         = 1'b0;
					next_r.busy             = 1'b1;
					next_r.ready_wait_phase = 1'b0;
				end
			end
			ebrw_pkg::EBRW_ACCESS: begin
				if (r.cnt != ebrw_pkg::EBRW_PHASE_ONE) begin
					next_r.cnt = r.cnt - ebrw_pkg::EBRW_PHASE_ONE;
				end else if (r.ready_en) begin
					next_r.state            = ebrw_pkg::EBRW_RDYW;
					next_r.ready_wait_phase = 1'b1;
				end else begin
					next_r.state    = ebrw_pkg::EBRW_DONE;
					next_r.strobe_b = 1'b1;
					if (!r.write) begin
						next_r.rdata = data_in;
					end
				end
			end
			ebrw_pkg::EBRW_RDYW: begin
				// Not ready: stay, one more wait state then sample again
				if (ready_seen) begin
					next_r.state            = ebrw_pkg::EBRW_DONE;
					next_r.strobe_b         = 1'b1;
					next_r.ready_wait_phase = 1'b0;
					if (!r.write) begin
						next_r.rdata = data_in;
					end
				end
			end
			ebrw_pkg::EBRW_DONE: begin
				next_r.state = ebrw_pkg::EBRW_IDLE;
				next_r.busy  = 1'b0;
				next_r.done  = 1'b1;
			end
			default: begin
				next_r.state = ebrw_pkg::EBRW_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			r <= '{state: ebrw_pkg::EBRW_IDLE, cnt: ebrw_pkg::EBRW_PHASE_ZERO, write: 1'b0,
				ready_en: 1'b0, strobe_b: 1'b1, busy: 1'b0, done: 1'b0,
				ready_wait_phase: 1'b0, async_mode: 1'b0, rdata: ebrw_pkg::EBRW_DATA_RST};
		end else begin
			r <= next_r;
		end
	end

	assign busy             = r.busy;
	assign strobe_b         = r.strobe_b;
	assign cycle_done       = r.done;
	assign ready_wait_phase = r.ready_wait_phase;
	assign read_data        = r.rdata;

	a_strobe_ends_on_ready: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(r.state == ebrw_pkg::EBRW_RDYW && ready_seen) |=> (strobe_b && !ready_wait_phase))
		else $error("ready did not end cycle");
	a_wait_on_not_ready: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(r.state == ebrw_pkg::EBRW_RDYW && !ready_seen) |=> (ready_wait_phase && !strobe_b))
		else $error("wait state not inserted");
	a_access_before_ready: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(r.state == ebrw_pkg::EBRW_IDLE && req.start && req.access_phase_len == 5'h03)
		|=> !ready_wait_phase [*3])
		else $error("ready evaluated too early");
	a_first_sample_place: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(r.state == ebrw_pkg::EBRW_IDLE && req.start && req.ready_en
		&& req.access_phase_len == 5'h02) |-> ##3 ready_wait_phase)
		else $error("first sample misplaced");
	a_async_min_wait: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(r.state == ebrw_pkg::EBRW_ACCESS && r.cnt == 5'h01 && r.ready_en && r.async_mode
		&& !ready_synced && !$past(ready_norm)) |=> ##1 !strobe_b)
		else $error("async ready bypassed synchroniser");
	// Judged on the raw pin, so a wrong polarity shows up as a wrong cycle end
	a_polarity_ready: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(r.state == ebrw_pkg::EBRW_RDYW && !r.async_mode && (ready_pin == ready_active_high))
		|=> strobe_b)
		else $error("selected ready level not honoured");
	a_polarity_wait: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(r.state == ebrw_pkg::EBRW_RDYW && !r.async_mode && (ready_pin != ready_active_high))
		|=> !strobe_b)
		else $error("inactive ready level ended cycle");
	a_read_capture: assert property (@(posedge ref_clk) disable iff (!rst_b)
		($rose(strobe_b) && !r.write) |-> (read_data == $past(data_in)))
		else $error("read data not captured");
	a_sync_direct: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(r.state == ebrw_pkg::EBRW_RDYW && !r.async_mode && ready_norm) |=> strobe_b)
		else $error("sync ready delayed");
	a_done_pulse: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$rose(strobe_b) |=> (cycle_done && !busy))
		else $error("cycle end missing");

	// Cycle start and access phase
	a_start_taken: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(r.state == ebrw_pkg::EBRW_IDLE && req.start)
		|=> (!strobe_b && busy && !ready_wait_phase))
		else $error("start not taken");
	a_strobe_busy: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!strobe_b |-> busy)
		else $error("strobe low outside a cycle");
	a_wait_needs_en: assert property (@(posedge ref_clk) disable iff (!rst_b)
		ready_wait_phase |-> (r.ready_en && !strobe_b))
		else $error("ready wait without ready control");
	// Ready seen during the access phase must not cut it short
	a_access_no_ready: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(r.state == ebrw_pkg::EBRW_ACCESS && r.cnt != ebrw_pkg::EBRW_PHASE_ONE)
		|=> (r.state == ebrw_pkg::EBRW_ACCESS && !ready_wait_phase && !strobe_b))
		else $error("access phase cut short");
	a_wait_enters: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(r.state == ebrw_pkg::EBRW_ACCESS && r.cnt == ebrw_pkg::EBRW_PHASE_ONE && r.ready_en)
		|=> (ready_wait_phase && !strobe_b))
		else $error("ready wait not entered");
	a_no_ready_end: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(r.state == ebrw_pkg::EBRW_ACCESS && r.cnt == ebrw_pkg::EBRW_PHASE_ONE && !r.ready_en)
		|=> (strobe_b && !ready_wait_phase))
		else $error("plain cycle did not end");
	a_len_zero_one: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(r.state == ebrw_pkg::EBRW_IDLE && req.start && !req.ready_en
		&& req.access_phase_len == 5'h00) |=> (!strobe_b ##1 strobe_b))
		else $error("zero length not one cycle");
	a_len_five_end: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(r.state == ebrw_pkg::EBRW_IDLE && req.start && !req.ready_en
		&& req.access_phase_len == 5'h05) |=> (!strobe_b [*5] ##1 strobe_b))
		else $error("programmed length not kept");

	// Ready sampling
	a_async_sample: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(r.state == ebrw_pkg::EBRW_RDYW && r.async_mode)
		|=> (strobe_b == $past(ready_synced)))
		else $error("async ready not taken from synchroniser");
	a_async_skip_pin: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(r.state == ebrw_pkg::EBRW_RDYW && r.async_mode && ready_norm && !ready_synced)
		|=> !strobe_b)
		else $error("async ready bypassed the synchroniser");
	// Two edges of latency, judged only once reset has been gone for both
	a_sync_chain: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$past(rst_b, 2) |-> (ready_synced == $past(ready_norm, 2)))
		else $error("synchroniser latency wrong");

	// Cycle end and read data
	a_done_single: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cycle_done |=> !cycle_done)
		else $error("done longer than one cycle");
	a_done_idle: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cycle_done |-> (!busy && strobe_b && !ready_wait_phase))
		else $error("done while cycle still running");
	a_busy_end: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$fell(busy) |-> cycle_done)
		else $error("busy dropped without done");
	a_rise_ends_wait: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$rose(strobe_b) |-> !ready_wait_phase)
		else $error("wait phase outlived the strobe");
	a_write_keeps_data: assert property (@(posedge ref_clk) disable iff (!rst_b)
		($rose(strobe_b) && r.write) |-> $stable(read_data))
		else $error("write cycle changed read data");
	// Read data only moves at the strobe-raising edge of a read
	a_data_stands: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!$rose(strobe_b) |-> $stable(read_data))
		else $error("read data changed outside a read end");

	c_sync_cycle:  cover property (@(posedge ref_clk) disable iff (!rst_b)
		r.state == ebrw_pkg::EBRW_RDYW && !r.async_mode && ready_seen);
	c_async_cycle: cover property (@(posedge ref_clk) disable iff (!rst_b)
		r.state == ebrw_pkg::EBRW_RDYW && r.async_mode && ready_seen);
	c_long_wait:   cover property (@(posedge ref_clk) disable iff (!rst_b)
		ready_wait_phase [*3]);
	c_plain_read:  cover property (@(posedge ref_clk) disable iff (!rst_b)
		cycle_done && !r.ready_en && !r.write);
	c_refused_start: cover property (@(posedge ref_clk) disable iff (!rst_b)
		busy && req.start);
endmodule
`default_nettype wire

// [ebrw_periph.sv]
// Peripheral model that stretches bus cycles through the ready input
`timescale 1ns/10ps
`default_nettype none
module ebrw_periph (
	input  wire logic        ref_clk,
	input  wire logic        strobe_b,
	input  wire logic        act_high,
	input  wire logic [4:0]  delay,
	input  wire logic [15:0] word,
	output logic             ready_pin,
	output logic [15:0]      data_out
);
	logic [4:0] cnt = 5'h00;
	logic       active;
	// Counts on the reference clock, so ready is also fit for sync handling
	always @(posedge ref_clk) cnt <= strobe_b ? 5'h00 : cnt + 5'h01;
	// Held until the strobe rises, dropped one cycle later: long enough to sync
	assign active = (cnt != 5'h00) && (cnt >= delay);
	assign ready_pin = ~(active ^ act_high);
	// Released bus shows the inverse so a late capture cannot match
	assign data_out = strobe_b ? ~word : word;
endmodule
`default_nettype wire

// [ext_bus_ready_waitstate_ctrl_test.sv]
// Self-checking bench for the ready wait-state controller
`timescale 1ns/10ps
`default_nettype none
module ext_bus_ready_waitstate_ctrl_test;
	logic                ref_clk   = 1'b0;
	logic                rst_b     = 1'b0;
	ebrw_pkg::ebrw_req_t req       = '0;
	logic                act_high  = 1'b1;
	logic                async_sel = 1'b0;
	logic [4:0]          delay     = 5'h01;
	logic [15:0]         word      = 16'h0000;
	logic                ready_pin;
	logic [15:0]         data_in;
	logic                busy;
	logic                strobe_b;
	logic                cycle_done;
	logic                rdy_wait;
	logic [15:0]         read_data;
	int                  err_count = 0;
	int                  n_checks  = 0;

	ebrw_ctrl u_ebrw_ctrl (.ref_clk(ref_clk), .rst_b(rst_b), .req(req),
		.ready_pin(ready_pin), .ready_active_high(act_high), .ready_async(async_sel),
		.data_in(data_in), .busy(busy), .strobe_b(strobe_b), .cycle_done(cycle_done),
		.ready_wait_phase(rdy_wait), .read_data(read_data));
	ebrw_periph u_ebrw_periph (.ref_clk(ref_clk), .strobe_b(strobe_b), .act_high(act_high),
		.delay(delay), .word(word), .ready_pin(ready_pin), .data_out(data_in));

	initial forever #50 ref_clk = ~ref_clk;

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		if (err_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// One bus cycle; a second start is pulsed while busy and must be ignored
	task automatic bus_cycle(input logic wr, input logic en, input logic [4:0] len,
		input logic [4:0] d);
		int n;
		int w;
		int e;
		n = 0;
		w = 0;
		e = (len == 5'h00) ? 1 : int'(len);
		delay = d;
		word = {6'h2D, len, d};
		req = '{1'b1, wr, en, len};
		@(posedge ref_clk) #10;
		while (strobe_b === 1'b0 && n < 64) begin
			n++;
			w += (rdy_wait === 1'b1);
			req.start = (n == 1);
			@(posedge ref_clk) #10;
		end
		req.start = 1'b0;
		check(16'(w), 16'(en ? n - e : 0));
		if (en)
			e = ((e > int'(d)) ? e : int'(d)) + 1;
		check(16'(n >= e + async_sel && n <= e + 2 * async_sel), 16'h0001);
		if (!wr)
			check(read_data, word);
		check({14'h0000, cycle_done, busy}, 16'h0001);
		@(posedge ref_clk) #10;
		check({14'h0000, cycle_done, busy}, 16'h0002);
		@(posedge ref_clk) #10;
		check({15'h0000, strobe_b}, 16'h0001);
	endtask

	initial begin
		repeat (8) @(posedge ref_clk);
		#10;
		check({12'h000, busy, strobe_b, cycle_done, rdy_wait}, 16'h0004);
		check(read_data, 16'h0000);
		rst_b = 1'b1;
		bus_cycle(1'b0, 1'b0, 5'h00, 5'h01);
		bus_cycle(1'b1, 1'b0, 5'h05, 5'h01);
		for (int p = 0; p < 4; p++) begin
			act_high = p[0];
			async_sel = p[1];
			bus_cycle(p[0], 1'b1, 5'h02, 5'h01);
			bus_cycle(p[0], 1'b1, 5'h03, 5'h02);
			bus_cycle(~p[0], 1'b1, 5'h01, 5'h06);
		end
		wrap_up();
	end

	// Whole run is about 12 microseconds; far beyond that means a hang
	initial begin
		#100000;
		err_count++;
		wrap_up();
	end
endmodule
`default_nettype wire
